// ---- design/wdtsa_pkg.sv ----
// Constants, register map and mode type of the sleep-aware watchdog.
// Assumes a 50 MHz system clock and a slow internal oscillator on a pin.
package wdtsa_pkg;
   // ****************************************
   // Register map (Wishbone byte addresses)
   // ****************************************
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STAT = 4'h4;
   localparam int CTRL_SWEN_BIT = 0;
   localparam int CTRL_PS_LSB = 1;
   localparam int PS_W = 5;
   // 2^11 ms, the nominal two-second period
   localparam logic [4:0] PS_RESET = 5'h0B;
   // 2^18 ms, the nominal 256-second period
   localparam logic [4:0] PS_MAX = 5'h12;
   localparam logic SWEN_RESET = 1'b0;
   localparam int STAT_TO_BIT = 0;
   localparam int STAT_PD_BIT = 1;
   localparam int STAT_ACTIVE_BIT = 2;
   localparam int STAT_ASLEEP_BIT = 3;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 50000000;
   localparam int LF_OSC_HZ = 31000;
   localparam int TICK_US = 1000;
   localparam int TICK_EDGES = (LF_OSC_HZ / 1000) * TICK_US / 1000;
   localparam int CNT_W = 19;
   // ****************************************
   // Modes
   // ****************************************
   typedef enum logic [1:0] {
      WDTSA_MODE_OFF = 2'b00,
      WDTSA_MODE_SW = 2'b01,
      WDTSA_MODE_AWAKE = 2'b10,
      WDTSA_MODE_ON = 2'b11
   } wdtsa_mode_t;
endpackage

// ---- design/wdtsa_sync2.sv ----
// Two-flop synchroniser for pin inputs.
// Assumes inputs may change at any time relative to clk_i.
`timescale 1ns/1ns
`default_nettype none
module wdtsa_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   if (WIDTH < 1) begin : g_bad_width
      $error("wdtsa_sync2: WIDTH must be at least 1");
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;
endmodule
`default_nettype wire

// ---- design/wdtsa_tick.sv ----
// Nominal 1 ms tick from the synchronised slow oscillator.
// Assumes osc_i is already synchronised to clk_i.
`timescale 1ns/1ns
`default_nettype none
module wdtsa_tick #(
   parameter int EDGES = wdtsa_pkg::TICK_EDGES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Oscillator and control
   input wire logic osc_i,
   input wire logic clear_i,
   output logic tick_o
);
   logic osc_prev_ff;
   logic [7:0] edge_cnt_ff;
   logic tick_ff;
   logic osc_rise;

   if (EDGES < 3 || EDGES > 255) begin : g_bad_edges
      $error("wdtsa_tick: EDGES out of range");
   end

   assign osc_rise = osc_i & ~osc_prev_ff;

   // Divider restarts on every clear so a fresh period is a full one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_prev_ff <= 1'b0;
         edge_cnt_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         osc_prev_ff <= osc_i;
         tick_ff <= 1'b0;
         if (clear_i) begin
            edge_cnt_ff <= 8'h00;
         end else if (osc_rise) begin
            if (edge_cnt_ff == 8'(EDGES - 1)) begin
               edge_cnt_ff <= 8'h00;
               tick_ff <= 1'b1;
            end else begin
               edge_cnt_ff <= edge_cnt_ff + 8'h01;
            end
         end
      end
   end

   assign tick_o = tick_ff;

   chk_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
      tick_o |=> !tick_o [*2])
      else $error("tick not isolated");
endmodule
`default_nettype wire

// ---- design/wdtsa_top.sv ----
// Sleep-aware watchdog timer with a Wishbone register slave.
// Assumes the core drives sleep and clear strobes on clk_i; the slow
// oscillator, oscillator-fail and start-up-timer levels are asynchronous pins.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Counter runs on 1 ms slow-oscillator ticks
// - Mode 00 keeps the watchdog off
// - Mode 11 always active, even asleep
// - Mode 10 active awake, off asleep
// - Mode 01 follows software enable bit
// - Prescale selects 1 ms to 256 s
// - Prescale resets to two-second period
// - Listed events clear the counter
// - Counting in sleep only if enabled
// - Wake clears; start-up timer holds clear
// - Sleep timeout wakes, sets both flags
module wdtsa_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Oscillator pins
   input wire logic low_freq_internal_osc_i,
   input wire logic osc_fail_i,
   input wire logic osc_startup_timer_i,
   // Core side
   input wire logic [1:0] watchdog_mode_field_i,
   input wire logic core_sleep_i,
   input wire logic clear_watchdog_instr_i,
   // Watchdog results
   output logic wdt_reset_o,
   output logic wdt_wake_o,
   output logic wdt_active_o,
   output logic timeout_status_flag_o,
   output logic powerdown_status_flag_o
);
   // ****************************************
   // Declarations
   // ****************************************
   localparam int CNT_W = wdtsa_pkg::CNT_W;
   localparam int PS_W = wdtsa_pkg::PS_W;

   wdtsa_pkg::wdtsa_mode_t mode;
   logic [2:0] pin_sync;
   logic osc_s;
   logic fail_s;
   logic ost_s;
   logic tick;
   logic soft_watchdog_enable_ff;
   logic [PS_W-1:0] timeout_prescale_select_ff;
   logic active_ff;
   logic nxt_active;
   logic sleep_prev_ff;
   logic sleep_edge;
   logic hold_clear;
   logic hit;
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] limit;
   logic reset_ff;
   logic wake_ff;
   logic to_ff;
   logic pd_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic bus_req;
   logic wr_commit;
   logic wr_ctrl;
   logic wr_stat;

   // Period of 2^ps ms, counted as a terminal value
   function automatic logic [CNT_W-1:0] period_lim(input logic [PS_W-1:0] ps);
      logic [CNT_W-1:0] one;
      one = CNT_W'(1);
      period_lim = (one << ps) - one;
   endfunction

   // Reserved prescale codes fall back to the longest period
   function automatic logic [PS_W-1:0] ps_clamp(input logic [PS_W-1:0] ps);
      ps_clamp = (ps > wdtsa_pkg::PS_MAX) ? wdtsa_pkg::PS_MAX : ps;
   endfunction

   // ****************************************
   // Pin inputs and time base
   // ****************************************
   wdtsa_sync2 #(
      .WIDTH(3)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({osc_startup_timer_i, osc_fail_i, low_freq_internal_osc_i}),
      .q_o(pin_sync)
   );

   assign osc_s = pin_sync[0];
   assign fail_s = pin_sync[1];
   assign ost_s = pin_sync[2];

   wdtsa_tick #(
      .EDGES(wdtsa_pkg::TICK_EDGES)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .osc_i(osc_s),
      .clear_i(hold_clear | hit),
      .tick_o(tick)
   );

   // ****************************************
   // Mode decode
   // ****************************************
   assign mode = wdtsa_pkg::wdtsa_mode_t'(watchdog_mode_field_i);

   always_comb begin
      nxt_active = 1'b0;
      unique case (mode)
         wdtsa_pkg::WDTSA_MODE_OFF: nxt_active = 1'b0;
         wdtsa_pkg::WDTSA_MODE_SW: nxt_active = soft_watchdog_enable_ff;
         wdtsa_pkg::WDTSA_MODE_AWAKE: nxt_active = ~core_sleep_i;
         wdtsa_pkg::WDTSA_MODE_ON: nxt_active = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_ff <= 1'b0;
         sleep_prev_ff <= 1'b0;
      end else begin
         active_ff <= nxt_active;
         sleep_prev_ff <= core_sleep_i;
      end
   end

   // ****************************************
   // Counter
   // ****************************************
   // Both sleep entry and wake are edges of the same level
   assign sleep_edge = core_sleep_i ^ sleep_prev_ff;
   assign hold_clear = clear_watchdog_instr_i | sleep_edge | fail_s | ost_s | ~nxt_active;
   assign limit = period_lim(timeout_prescale_select_ff);
   // Compare by >= so a shorter period written mid-count still ends promptly
   assign hit = tick & active_ff & ~hold_clear & (count_ff >= limit);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_ff <= '0;
      end else if (hold_clear | hit) begin
         count_ff <= '0;
      end else if (tick & active_ff) begin
         count_ff <= count_ff + CNT_W'(1);
      end
   end

   // ****************************************
   // Time-out outcome
   // ****************************************
   // Asleep the core is woken instead of reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         reset_ff <= hit & ~core_sleep_i;
         wake_ff <= hit & core_sleep_i;
      end
   end

   // Flags survive the watchdog reset pulse; only rst_i or software clears.
   // A time-out in the clearing cycle wins over the clear.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         to_ff <= 1'b0;
         pd_ff <= 1'b0;
      end else begin
         if (hit) begin
            to_ff <= 1'b1;
         end else if (wr_stat && wb_dat_i[wdtsa_pkg::STAT_TO_BIT]) begin
            to_ff <= 1'b0;
         end
         if (hit && core_sleep_i) begin
            pd_ff <= 1'b1;
         end else if (wr_stat && wb_dat_i[wdtsa_pkg::STAT_PD_BIT]) begin
            pd_ff <= 1'b0;
         end
      end
   end

   // ****************************************
   // Wishbone slave
   // ****************************************
   // Ack one cycle after the request; writes land on the acked edge
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_commit = bus_req & ack_ff & wb_we_i & wb_sel_i[0];
   assign wr_ctrl = wr_commit & (wb_adr_i == wdtsa_pkg::ADR_CTRL);
   assign wr_stat = wr_commit & (wb_adr_i == wdtsa_pkg::ADR_STAT);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end else begin
         ack_ff <= bus_req & ~ack_ff;
         if (bus_req && !ack_ff) begin
            unique case (wb_adr_i)
               wdtsa_pkg::ADR_CTRL: dat_ff <= {26'h0000000, timeout_prescale_select_ff,
                                               soft_watchdog_enable_ff};
               wdtsa_pkg::ADR_STAT: dat_ff <= {28'h0000000, core_sleep_i, active_ff,
                                               pd_ff, to_ff};
               default: dat_ff <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_watchdog_enable_ff <= wdtsa_pkg::SWEN_RESET;
         timeout_prescale_select_ff <= wdtsa_pkg::PS_RESET;
      end else if (wr_ctrl) begin
         soft_watchdog_enable_ff <= wb_dat_i[wdtsa_pkg::CTRL_SWEN_BIT];
         timeout_prescale_select_ff <=
            ps_clamp(wb_dat_i[wdtsa_pkg::CTRL_PS_LSB +: PS_W]);
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign wdt_reset_o = reset_ff;
   assign wdt_wake_o = wake_ff;
   assign wdt_active_o = active_ff;
   assign timeout_status_flag_o = to_ff;
   assign powerdown_status_flag_o = pd_ff;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_awake_timeout;
      hit && !core_sleep_i;
   endsequence

   sequence s_reset_recorded;
      wdt_reset_o && !wdt_wake_o ##1 timeout_status_flag_o;
   endsequence

   sequence s_sleep_timeout;
      hit && core_sleep_i;
   endsequence

   sequence s_wake_recorded;
      wdt_wake_o && !wdt_reset_o ##1 timeout_status_flag_o && powerdown_status_flag_o;
   endsequence

   chk_mode_off_idle: assert property (
      mode == wdtsa_pkg::WDTSA_MODE_OFF |=> !wdt_active_o ##0 count_ff == '0)
      else $error("watchdog active in off mode");

   chk_mode_always_on: assert property (
      mode == wdtsa_pkg::WDTSA_MODE_ON |=> wdt_active_o)
      else $error("watchdog idle in always-on mode");

   chk_sleep_disables: assert property (
      mode == wdtsa_pkg::WDTSA_MODE_AWAKE |=> wdt_active_o == !$past(core_sleep_i))
      else $error("awake-only mode wrong in sleep");

   chk_soft_enable: assert property (
      mode == wdtsa_pkg::WDTSA_MODE_SW |=> wdt_active_o == $past(soft_watchdog_enable_ff))
      else $error("software mode ignores enable bit");

   chk_period_match: assert property (
      tick && active_ff && !hold_clear && count_ff >= limit |=> wdt_reset_o || wdt_wake_o)
      else $error("time-out at wrong count");

   chk_prescale_reset: assert property (
      $fell(rst_i) |-> timeout_prescale_select_ff == wdtsa_pkg::PS_RESET)
      else $error("prescale not at two-second default");

   chk_clear_events: assert property (
      clear_watchdog_instr_i || fail_s || sleep_edge |=> count_ff == '0)
      else $error("counter not cleared on event");

   chk_sleep_counting: assert property (
      core_sleep_i && !sleep_edge && !hold_clear && active_ff && tick && !hit
      |=> count_ff == $past(count_ff) + CNT_W'(1))
      else $error("counter stalled in enabled sleep");

   chk_startup_hold: assert property (
      ost_s [*2] |-> count_ff == '0)
      else $error("counter moved during start-up timer");

   chk_sleep_wakes: assert property (
      s_sleep_timeout |=> s_wake_recorded)
      else $error("sleep time-out did not wake");

   chk_awake_resets: assert property (
      s_awake_timeout |=> s_reset_recorded)
      else $error("awake time-out did not reset");
endmodule
`default_nettype wire

// ---- dv/wdtsa_core_model.sv ----
// Behavioural core: sleeps on request, clears the watchdog when awake.
// Assumes bench requests are one-cycle pulses on clk_i.
`timescale 1ns/1ns
`default_nettype none
module wdtsa_core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bench requests
   input wire logic sleep_req_i,
   input wire logic wake_req_i,
   input wire logic clr_req_i,
   // Watchdog results
   input wire logic wdt_wake_i,
   input wire logic wdt_reset_i,
   // Core outputs
   output logic core_sleep_o,
   output logic clear_o
);
   // ****************
   // Core state
   // ****************
   always_ff @(posedge clk_i) begin
      if (rst_i || wdt_wake_i || wdt_reset_i || wake_req_i) begin
         core_sleep_o <= 1'b0;
      end else if (sleep_req_i) begin
         core_sleep_o <= 1'b1;
      end
   end
   // A sleeping core runs no instructions, so it cannot clear
   always_ff @(posedge clk_i) begin
      clear_o <= clr_req_i && !core_sleep_o && !rst_i;
   end
endmodule
`default_nettype wire

// ---- dv/wdtsa_top_test.sv ----
// Self-checking bench for the sleep-aware watchdog top.
// Assumes a slow oscillator sped up to 12 clocks a period.
`timescale 1ns/1ns
`default_nettype none
module wdtsa_top_test;
   // ****************
   // Signals
   // ****************
   logic clk_i;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [3:0] wsel = 4'hF;
   logic to_flag;
   logic pd_flag;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic wb_ack_o;
   logic osc = 1'b0;
   logic osc_run = 1'b1;
   logic osc_fail = 1'b0;
   logic osc_startup_timer = 1'b0;
   logic [1:0] mode = 2'b00;
   logic sleep_req = 1'b0;
   logic wake_req = 1'b0;
   logic clr_req = 1'b0;
   logic core_sleep;
   logic clr;
   logic wdt_reset_o;
   logic wdt_wake_o;
   logic wdt_active_o;
   logic [31:0] n_rst = 32'h0;
   logic [31:0] n_wk = 32'h0;
   logic [31:0] r0;
   logic [31:0] w0;
   int n_errors = 0;
   int tests_run = 0;
   int ocnt = 0;
   int m;
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Stopping the oscillator freezes ticks without a clear
   always @(posedge clk_i) begin
      ocnt <= (ocnt == 5) ? 0 : ocnt + 1;
      if (ocnt == 5 && osc_run) begin
         osc <= ~osc;
      end
   end
   always @(posedge clk_i) begin
      n_rst <= n_rst + {31'h0, wdt_reset_o === 1'b1};
      n_wk <= n_wk + {31'h0, wdt_wake_o === 1'b1};
   end
   wdtsa_top dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .low_freq_internal_osc_i(osc), .osc_fail_i(osc_fail),
      .osc_startup_timer_i(osc_startup_timer), .watchdog_mode_field_i(mode),
      .core_sleep_i(core_sleep), .clear_watchdog_instr_i(clr),
      .wdt_reset_o(wdt_reset_o), .wdt_wake_o(wdt_wake_o),
      .wdt_active_o(wdt_active_o), .timeout_status_flag_o(to_flag),
      .powerdown_status_flag_o(pd_flag)
   );
   wdtsa_core_model core (
      .clk_i(clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req),
      .wake_req_i(wake_req), .clr_req_i(clr_req), .wdt_wake_i(wdt_wake_o),
      .wdt_reset_i(wdt_reset_o), .core_sleep_o(core_sleep), .clear_o(clr)
   );
   // ****************
   // Tasks
   // ****************
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic cycle; waits for ack under a bound
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
      int i = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= wsel;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED at %0t: bus timeout", $time);
         final_report();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      chk(rd, exp);
   endtask
   initial begin
      #2000000;
      n_errors++;
      $display("CHECK FAILED at %0t: run timeout", $time);
      final_report();
   end
   // ****************
   // Tests
   // ****************
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdchk(wdtsa_pkg::ADR_CTRL, {26'h0, wdtsa_pkg::PS_RESET, wdtsa_pkg::SWEN_RESET});
      rdchk(wdtsa_pkg::ADR_STAT, 32'h0);
      rdchk(4'h8, 32'h0);
      wb(1'b1, wdtsa_pkg::ADR_CTRL, 32'h3F);
      rdchk(wdtsa_pkg::ADR_CTRL, {26'h0, wdtsa_pkg::PS_MAX, 1'b1});
      // Lane 0 disabled, so the write must be dropped
      wsel = 4'hE;
      wb(1'b1, wdtsa_pkg::ADR_CTRL, 32'h0);
      wsel = 4'hF;
      rdchk(wdtsa_pkg::ADR_CTRL, {26'h0, wdtsa_pkg::PS_MAX, 1'b1});
      $display("test registers done");
      wb(1'b1, wdtsa_pkg::ADR_CTRL, 32'h0);
      for (m = 0; m < 5; m++) begin
         if (m == 4) wb(1'b1, wdtsa_pkg::ADR_CTRL, 32'h1);
         mode <= (m == 4) ? 2'b01 : m[1:0];
         r0 = n_rst;
         repeat (900) @(posedge clk_i);
         chk({31'h0, n_rst != r0}, {31'h0, m >= 2});
         chk({31'h0, wdt_active_o}, {31'h0, m >= 2});
      end
      rdchk(wdtsa_pkg::ADR_STAT, 32'h5);
      chk({30'h0, pd_flag, to_flag}, 32'h1);
      $display("test awake modes done");
      // Period of four ticks, so a wake cannot be followed by a reset in the window
      wb(1'b1, wdtsa_pkg::ADR_CTRL, 32'h5);
      for (m = 3; m > 0; m--) begin
         mode <= 2'b00;
         wb(1'b1, wdtsa_pkg::ADR_STAT, 32'h3);
         mode <= m[1:0];
         sleep_req <= 1'b1;
         @(posedge clk_i);
         sleep_req <= 1'b0;
         r0 = n_rst;
         w0 = n_wk;
         repeat (2000) @(posedge clk_i);
         chk(n_wk - w0, (m == 2) ? 32'h0 : 32'h1);
         chk(n_rst - r0, 32'h0);
         rdchk(wdtsa_pkg::ADR_STAT, (m == 2) ? 32'h8 : 32'h7);
         chk({30'h0, pd_flag, to_flag}, (m == 2) ? 32'h0 : 32'h3);
         wake_req <= 1'b1;
         @(posedge clk_i);
         wake_req <= 1'b0;
      end
      $display("test sleep done");
      mode <= 2'b00;
      wb(1'b1, wdtsa_pkg::ADR_CTRL, 32'h4);
      wb(1'b1, wdtsa_pkg::ADR_STAT, 32'h3);
      rdchk(wdtsa_pkg::ADR_STAT, 32'h0);
      mode <= 2'b11;
      r0 = n_rst;
      repeat (12) begin
         repeat (300) @(posedge clk_i);
         clr_req <= 1'b1;
         @(posedge clk_i);
         clr_req <= 1'b0;
      end
      chk(n_rst - r0, 32'h0);
      osc_run <= 1'b0;
      repeat (3000) @(posedge clk_i);
      chk(n_rst - r0, 32'h0);
      osc_run <= 1'b1;
      osc_startup_timer <= 1'b1;
      repeat (3000) @(posedge clk_i);
      chk(n_rst - r0, 32'h0);
      osc_startup_timer <= 1'b0;
      osc_fail <= 1'b1;
      repeat (3000) @(posedge clk_i);
      chk(n_rst - r0, 32'h0);
      osc_fail <= 1'b0;
      repeat (2000) @(posedge clk_i);
      chk(n_rst - r0, 32'h1);
      rdchk(wdtsa_pkg::ADR_STAT, 32'h5);
      chk({30'h0, pd_flag, to_flag}, 32'h1);
      $display("test clear sources done");
      // Mid-run reset: counter, flags and control return to defaults
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({30'h0, pd_flag, to_flag}, 32'h0);
      rdchk(wdtsa_pkg::ADR_CTRL, {26'h0, wdtsa_pkg::PS_RESET, wdtsa_pkg::SWEN_RESET});
      rdchk(wdtsa_pkg::ADR_STAT, 32'h4);
      $display("test mid-run reset done");
      final_report();
   end
endmodule
`default_nettype wire
